// file: tb_tci_core.sv
// self-checking bench for the call, halt and increment core
`timescale 1ns/1ns
`default_nettype none
module tb_tci_core;
	import tci_pkg::*;
	logic        sys_clk_in = 1'b0, rstn_in = 1'b0, start_in = 1'b0;
	logic        irq_in = 1'b0, ext_stack_in = 1'b0;
	logic [7:0]  opcode_in = 8'h00, operand_in = 8'h00, a;
	logic        rom_wr, busy, done, ill, clk_en;
	logic [15:0] rom_addr, w;
	logic [7:0]  rom_data;
	logic [7:0]  regs [256];
	logic [31:0] lfsr = 32'h4C0CD782;
	tci_arch_t   arch, exp;
	int          err_total = 0, cmp_count = 0, cyc = 0, len, n;
	logic [15:0] corner [4] = '{16'h007D, 16'h7FFD, 16'h00FD, 16'hFFFD};
	tci_core #(.ROM_AW(16)) u_tci_core (.sys_clk_in(sys_clk_in),
		.rstn_in(rstn_in), .start_in(start_in), .opcode_in(opcode_in),
		.operand_in(operand_in), .irq_in(irq_in), .rom_wr_in(rom_wr),
		.rom_addr_in(rom_addr), .rom_data_in(rom_data),
		.ext_stack_in(ext_stack_in), .busy_out(busy), .done_out(done),
		.illegal_out(ill), .cpu_clk_en_out(clk_en), .arch_out(arch));
	tci_rom_feeder u_tci_rom_feeder (.sys_clk_in(sys_clk_in),
		.wr_out(rom_wr), .addr_out(rom_addr), .data_out(rom_data));
	initial forever #4 sys_clk_in = ~sys_clk_in;
	// cut a hang short
	always @(posedge sys_clk_in)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_total++;
			conclude();
		end
	end
	function automatic logic [31:0] step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// flags after an increment giving v
	function automatic logic [7:0] fl(input logic [7:0] f,
		input logic [15:0] v, input logic wd);
		f[FLG_Z] = v == 16'h0000;
		f[FLG_S] = wd ? v[15] : v[7];
		f[FLG_V] = v == (wd ? 16'h8000 : 16'h0080);
		return f;
	endfunction
	task automatic check(input string nm, input logic [55:0] got,
		input logic [55:0] want);
		cmp_count++;
		if (got !== want)
		begin
			err_total++;
			$display("BAD %s exp %h got %h", nm, want, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// issue one opcode, wait for its end, irq wakes a halt
	task automatic run(input logic [7:0] op, input logic [7:0] opd,
		input int lo);
		@(negedge sys_clk_in);
		opcode_in = op;
		operand_in = opd;
		start_in = 1'b1;
		@(negedge sys_clk_in);
		start_in = 1'b0;
		check("busy", 56'(busy), 56'(lo > 1));
		len = 1;
		while (done !== 1'b1 && ill !== 1'b1 && len < 60)
		begin
			if (len == 12 && op == OP_HALT)
			begin
				check("halted", 56'(clk_en), 56'h0);
				irq_in = 1'b1;
			end
			@(negedge sys_clk_in);
			len++;
		end
		check("end pulse", 56'({done, ill}), lo > 1 ? 56'h2 : 56'h1);
		irq_in = 1'b0;
		check("length", 56'(len >= lo && len < 60), 56'h1);
		@(negedge sys_clk_in);
	endtask
	task automatic call(input logic [15:0] wv);
		u_tci_rom_feeder.load(exp.pc, wv);
		run(OP_CALL, 8'h00, 14);
		exp.sp = exp.sp - PTR_STEP;
		regs[exp.sp[7:0]] = exp.tp[15:8];
		regs[exp.sp[7:0] + 8'h01] = exp.tp[7:0];
		exp.tp = exp.pc + PTR_STEP;
		exp.pc = wv;
		check("call", arch, exp);
	endtask
	task automatic ret(input logic [15:0] wv);
		exp.tp = {regs[exp.sp[7:0]], regs[exp.sp[7:0] + 8'h01]};
		u_tci_rom_feeder.load(exp.tp, wv);
		ext_stack_in = wv[0];
		run(OP_RET, 8'h00, wv[0] ? 16 : 14);
		exp.sp = exp.sp + PTR_STEP;
		exp.tp = exp.tp + PTR_STEP;
		exp.pc = wv;
		check("return", arch, exp);
	endtask
	task automatic inc(input logic [7:0] op, input logic [7:0] opd);
		logic [7:0]  t;
		logic [15:0] v;
		logic        wd;
		wd = op[7:1] == 7'h50;
		t = op[3:0] == OP_INC_WR_LO ? WR_BASE + {4'h0, op[7:4]}
			: op[0] ? regs[opd] : opd;
		t[0] = t[0] & ~wd;
		v = wd ? {regs[t], regs[t + 8'h01]} + 16'h0001
			: {8'h00, regs[t] + 8'h01};
		run(op, opd, wd ? 8 : 4);
		if (wd)
			regs[t] = v[15:8];
		regs[t + {7'h00, wd}] = v[7:0];
		exp.flags = fl(exp.flags, v, wd);
		check("increment", arch, exp);
	endtask
	// calls with increments on the pushed words, then halt and returns
	initial
	begin
		exp = '0;
		#16 rstn_in = 1'b1;
		for (n = 0; n < 34; n++)
		begin
			w = n < 4 ? corner[n] : lfsr[15:0] | 16'h00C0;
			lfsr = step(lfsr);
			call(w);
			a = exp.sp[7:0];
			if (n[0])
				inc(OP_WORD_PAIR, a);
			inc(OP_INC_REG, a + {7'h00, !n[0]});
			if (!n[0])
				inc(OP_WORD_PAIR, a);
			if (regs[a + 8'h01] >= a)
				inc(n[1] ? OP_INC_IND : OP_WORD_IND, a + 8'h01);
			if (n >= 32)
				inc({lfsr[3:0], OP_INC_WR_LO}, lfsr[11:4]);
		end
		run(OP_HALT, 8'h00, 4);
		check("halt", arch, exp);
		run(8'h00, 8'h00, 1);
		check("refused", arch, exp);
		for (n = 0; n < 4; n++)
		begin
			ret(lfsr[15:0]);
			lfsr = step(lfsr);
		end
		run(OP_HALT, 8'h00, 4);
		@(negedge sys_clk_in);
		opcode_in = OP_HALT;
		start_in = 1'b1;
		@(negedge sys_clk_in);
		start_in = 1'b0;
		repeat (8) @(negedge sys_clk_in);
		rstn_in = 1'b0;
		@(negedge sys_clk_in);
		rstn_in = 1'b1;
		check("reset wake", 56'(clk_en), 56'h1);
		check("reset state", arch, 56'h0);
		conclude();
	end
endmodule // tb_tci_core
`default_nettype wire

// file: tci_core.sv
// executes threaded call/return, halt and byte/word increment
`timescale 1ns/1ns
`default_nettype none
module tci_core
	import tci_pkg::*;
#(
	parameter int ROM_AW = 12
)(
	input  wire logic                  sys_clk_in,
	input  wire logic                  rstn_in,
	input  wire logic                  start_in,
	input  wire logic [7:0]            opcode_in,
	input  wire logic [7:0]            operand_in,
	input  wire logic                  irq_in,
	input  wire logic                  rom_wr_in,
	input  wire logic [15:0]           rom_addr_in,
	input  wire logic [7:0]            rom_data_in,
	input  wire logic                  ext_stack_in,
	output logic                       busy_out,
	output logic                       done_out,
	output logic                       illegal_out,
	output logic                       cpu_clk_en_out,
	output tci_pkg::tci_arch_t         arch_out
);
	import tci_pkg::*;

	typedef enum {
		ST_IDLE, ST_FETCH_IND, ST_RD_LO, ST_RD_HI, ST_WR_LO, ST_WR_HI,
		ST_ROM, ST_WAIT, ST_HALT
	} tci_state_t;

	typedef enum { K_NONE, K_CALL, K_RET, K_BYTE, K_WORD } tci_kind_t;

	tci_state_t   state, next_state;
	tci_kind_t    kind, next_kind;
	tci_arch_t    arch, next_arch;
	logic [7:0]   addr, next_addr;
	logic [15:0]  tmp, next_tmp;
	logic [4:0]   cnt, next_cnt;
	logic [4:0]   budget, next_budget;
	logic         done, next_done;
	logic         illegal, next_illegal;
	logic         irq_s1, irq_s2;
	tci_reg_req_t req;
	logic [7:0]   rd;
	logic [15:0]  rom_addr;
	logic [15:0]  rom_word;

	// flag update for an increment result of width 8 or 16
	function automatic logic [7:0] inc_flags(input logic [7:0] f,
		input logic [15:0] res, input logic wide);
		logic [7:0] o;
		logic       msb;
		logic       zero;
		logic       ovf;
		o    = f;
		msb  = wide ? res[15] : res[7];
		zero = wide ? (res == 16'h0000) : (res[7:0] == 8'h00);
		ovf  = wide ? (res == 16'h8000) : (res[7:0] == 8'h80);
		o[FLG_Z] = zero;
		o[FLG_S] = msb;
		o[FLG_V] = ovf;
		return o;
	endfunction

	tci_regram u_ram (
		.sys_clk_in  (sys_clk_in),
		.req_in      (req),
		.rd_data_out (rd)
	);

	tci_progrom #(.AW(ROM_AW)) u_rom (
		.sys_clk_in  (sys_clk_in),
		.wr_in       (rom_wr_in),
		.wr_addr_in  (rom_addr_in),
		.wr_data_in  (rom_data_in),
		.rd_addr_in  (rom_addr),
		.rd_word_out (rom_word)
	);

	// interrupt request synchroniser
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			irq_s1 <= 1'b0;
			irq_s2 <= 1'b0;
		end
		else
		begin
			irq_s1 <= irq_in;
			irq_s2 <= irq_s1;
		end
	end

	// sequencer next state
	always_comb
	begin
		next_state   = state;
		next_kind    = kind;
		next_arch    = arch;
		next_addr    = addr;
		next_tmp     = tmp;
		// count saturates so a long halt cannot wrap back under the budget
		next_cnt     = (&cnt) ? cnt : cnt + 5'h01;
		next_budget  = budget;
		next_done    = 1'b0;
		next_illegal = 1'b0;
		req          = '{wr: 1'b0, addr: addr, data: 8'h00};
		rom_addr     = arch.tp;
		case (state)
			ST_IDLE:
			begin
				next_cnt = 5'h01;
				if (start_in)
				begin
					if (opcode_in == OP_CALL)
					begin
						next_kind   = K_CALL;
						next_budget = CYC_CALL;
						next_arch.sp = arch.sp - PTR_STEP;
						next_addr   = 8'(arch.sp - PTR_STEP);
						next_tmp    = arch.tp;
						next_state  = ST_WR_HI;
					end
					else if (opcode_in == OP_RET)
					begin
						next_kind   = K_RET;
						next_budget = ext_stack_in ? CYC_RET_EXT : CYC_RET;
						next_addr   = arch.sp[7:0];
						next_state  = ST_RD_HI;
					end
					else if (opcode_in == OP_HALT)
					begin
						next_budget = CYC_HALT;
						next_state  = ST_HALT;
					end
					else if (opcode_in[3:0] == OP_INC_WR_LO)
					begin
						next_kind   = K_BYTE;
						next_budget = CYC_BYTE;
						next_addr   = WR_BASE | {4'h0, opcode_in[7:4]};
						next_state  = ST_RD_LO;
					end
					else if (opcode_in == OP_INC_REG || opcode_in == OP_INC_IND)
					begin
						next_kind   = K_BYTE;
						next_budget = CYC_BYTE;
						next_addr   = operand_in;
						next_state  = (opcode_in == OP_INC_IND) ?
							ST_FETCH_IND : ST_RD_LO;
					end
					else if (opcode_in == OP_WORD_PAIR || opcode_in == OP_WORD_IND)
					begin
						next_kind   = K_WORD;
						next_budget = CYC_WORD;
						next_addr   = (opcode_in == OP_WORD_IND) ?
							operand_in : {operand_in[7:1], 1'b0};
						next_state  = (opcode_in == OP_WORD_IND) ?
							ST_FETCH_IND : ST_RD_HI;
					end
					else
						next_illegal = 1'b1;
				end
			end
			ST_FETCH_IND:
			begin
				// rd is pointer byte after one read cycle
				if (cnt[0] == 1'b0)
				begin
					next_addr  = (kind == K_WORD) ? {rd[7:1], 1'b0} : rd;
					next_state = (kind == K_WORD) ? ST_RD_HI : ST_RD_LO;
				end
			end
			ST_RD_HI:
			begin
				// even byte is high half; read data lag the address a cycle
				if (cnt[0] == 1'b0)
				begin
					next_tmp[15:8] = rd;
					next_addr      = {addr[7:1], 1'b1};
					next_state     = ST_RD_LO;
				end
			end
			ST_RD_LO:
			begin
				// low byte stands on the even count; use it straight away
				if (cnt[0] == 1'b0)
				begin
					if (kind == K_BYTE)
					begin
						next_tmp = {8'h00, rd + 8'h01};
						next_arch.flags = inc_flags(arch.flags,
							{8'h00, 8'(rd + 8'h01)}, 1'b0);
						next_state = ST_WR_LO;
					end
					else if (kind == K_RET)
					begin
						next_arch.tp = {tmp[15:8], rd};
						next_arch.sp = arch.sp + PTR_STEP;
						next_state   = ST_ROM;
					end
					else
					begin
						next_tmp = {tmp[15:8], rd} + 16'h0001;
						next_arch.flags = inc_flags(arch.flags,
							16'({tmp[15:8], rd} + 16'h0001), 1'b1);
						// write back starts at the even high byte
						next_addr  = {addr[7:1], 1'b0};
						next_state = ST_WR_HI;
					end
				end
			end
			ST_WR_HI:
			begin
				// store high byte, then low byte at odd address
				req = '{wr: 1'b1, addr: addr, data: tmp[15:8]};
				next_addr  = {addr[7:1], 1'b1};
				next_state = ST_WR_LO;
			end
			ST_WR_LO:
			begin
				req = '{wr: 1'b1, addr: addr, data: tmp[7:0]};
				if (kind == K_CALL)
				begin
					next_arch.tp = arch.pc;
					next_state   = ST_ROM;
				end
				else
					next_state = ST_WAIT;
			end
			ST_ROM:
			begin
				// rom word valid on the cycle after the address settles;
				// tmp bit 0 is free here and marks that second cycle
				if (tmp[0] == 1'b1)
				begin
					next_arch.pc = rom_word;
					next_arch.tp = arch.tp + PTR_STEP;
					next_state   = ST_WAIT;
				end
				next_tmp[0] = 1'b1;
			end
			ST_WAIT:
			begin
				// pad to the documented cycle count; flags untouched
				if (cnt >= budget)
				begin
					next_done  = 1'b1;
					next_kind  = K_NONE;
					next_state = ST_IDLE;
				end
			end
			ST_HALT:
			begin
				// cpu clock gated until interrupt; reset also releases
				if (irq_s2 && cnt >= budget)
				begin
					next_done  = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default:
				next_state = ST_IDLE;
		endcase
		if (state == ST_WR_LO && kind == K_CALL)
			next_tmp[0] = 1'b0;
		if (state == ST_RD_LO && next_state == ST_ROM)
			next_tmp[0] = 1'b0;
	end

	// sequencer registers
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			state   <= ST_IDLE;
			kind    <= K_NONE;
			arch    <= '{pc: PC_RESET, sp: SP_RESET, tp: TP_RESET, flags: FLG_RESET};
			addr    <= 8'h00;
			tmp     <= 16'h0000;
			cnt     <= 5'h00;
			budget  <= 5'h00;
			done    <= 1'b0;
			illegal <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			kind    <= next_kind;
			arch    <= next_arch;
			addr    <= next_addr;
			tmp     <= next_tmp;
			cnt     <= next_cnt;
			budget  <= next_budget;
			done    <= next_done;
			illegal <= next_illegal;
		end
	end

	assign busy_out       = (state != ST_IDLE);
	assign done_out       = done;
	assign illegal_out    = illegal;
	assign cpu_clk_en_out = (state != ST_HALT);
	assign arch_out       = arch;
endmodule // tci_core
`default_nettype wire

// file: tci_core_assertions.sv
// port assertions for the core
`timescale 1ns/1ns
`default_nettype none
module tci_core_assertions
	import tci_pkg::*;
(
	input wire logic               sys_clk_in,
	input wire logic               rstn_in,
	input wire logic               start_in,
	input wire logic [7:0]         opcode_in,
	input wire logic               irq_in,
	input wire logic               busy_out,
	input wire logic               done_out,
	input wire logic               cpu_clk_en_out,
	input wire tci_pkg::tci_arch_t arch_out
);
	logic [7:0] op, next_op;
	logic [4:0] cnt, next_cnt;
	tci_arch_t  st, next_st;
	logic       take, inc_op, wide;
	// opcode, state and age of the instruction in flight
	always_comb
	begin
		take = start_in && !busy_out;
		wide = op[7:1] == 7'h50;
		inc_op = op[3:0] == OP_INC_WR_LO || op[7:1] == 7'h10 || wide;
		next_op = take ? opcode_in : op;
		next_st = take ? arch_out : st;
		next_cnt = take ? 5'h01 : cnt + {4'h0, cnt != 5'h1F};
	end
	always_ff @(posedge sys_clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			op <= 8'h00;
			cnt <= 5'h00;
			st <= '0;
		end
		else
		begin
			op <= next_op;
			cnt <= next_cnt;
			st <= next_st;
		end
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rstn_in);
	a_call_stack: assert property (done_out && op == OP_CALL
		|=> arch_out.sp == st.sp - PTR_STEP) else $error("call sp");
	a_call_thread: assert property (done_out && op == OP_CALL
		|=> arch_out.tp == st.pc + PTR_STEP) else $error("call tp");
	a_call_time: assert property (done_out && op == OP_CALL
		|-> cnt >= CYC_CALL) else $error("call short");
	a_ret_stack: assert property (done_out && op == OP_RET
		|=> arch_out.sp == st.sp + PTR_STEP) else $error("ret sp");
	a_ret_time: assert property (done_out && op == OP_RET
		|-> cnt >= CYC_RET) else $error("ret short");
	a_flag_hold: assert property (take && (opcode_in == OP_CALL
		|| opcode_in == OP_RET || opcode_in == OP_HALT)
		|=> $stable(arch_out.flags)[*8]) else $error("flags moved");
	a_halt_stop: assert property (take
		&& opcode_in == OP_HALT && !irq_in
		|-> ##[1:8] !cpu_clk_en_out) else $error("no halt");
	a_halt_wake: assert property (!cpu_clk_en_out && irq_in
		|-> ##[1:8] cpu_clk_en_out) else $error("no wake");
	a_inc_time: assert property (done_out && inc_op
		|-> cnt >= (wide ? CYC_WORD : CYC_BYTE)) else $error("inc short");
	a_inc_keep: assert property (done_out && inc_op
		|=> arch_out.flags[7] == st.flags[7]
		&& arch_out.flags[3:0] == st.flags[3:0]) else $error("flag hit");
endmodule // tci_core_assertions
bind tci_core tci_core_assertions u_chk (.sys_clk_in(sys_clk_in),
	.rstn_in(rstn_in), .start_in(start_in), .opcode_in(opcode_in),
	.irq_in(irq_in), .busy_out(busy_out), .done_out(done_out),
	.cpu_clk_en_out(cpu_clk_en_out), .arch_out(arch_out));
`default_nettype wire

// file: tci_pkg.sv
// package of constants and types for the threaded call, halt and increment unit
// Summary of operation
// - threaded call 1F (14 cycles): stack pointer drops two, old thread pointer pushed.
// - threaded call then copies program counter into thread pointer.
// - call loads program counter from word at thread pointer, pointer advances two.
// - threaded return 2F: thread pointer popped from stack, stack pointer rises two.
// - return loads program counter from word at thread pointer, adds two; 14/16 cycles.
// - call, return and halt leave every condition flag unchanged.
// - halt 6F (4 cycles) stops the cpu clock; oscillator keeps running.
// - halted core resumes on interrupt request or external reset.
// - byte increment adds one; opcodes rE, 20 and 21, four cycles each; the core takes six for 21.
// - byte increment sets zero, sign, overflow from result; other flags untouched.
// - word increment adds one to even byte pair; A0 pair, A1 indirect, 8 cycles; the core takes 9 for A1.
// - word increment sets zero, sign, overflow from 16-bit result; others untouched.
package tci_pkg;
	localparam logic [7:0] OP_CALL      = 8'h1F;
	localparam logic [7:0] OP_RET       = 8'h2F;
	localparam logic [7:0] OP_HALT      = 8'h6F;
	localparam logic [7:0] OP_INC_REG   = 8'h20;
	localparam logic [7:0] OP_INC_IND   = 8'h21;
	localparam logic [7:0] OP_WORD_PAIR = 8'hA0;
	localparam logic [7:0] OP_WORD_IND  = 8'hA1;
	localparam logic [3:0] OP_INC_WR_LO = 4'hE;
	localparam logic [7:0] WR_BASE      = 8'hC0;
	localparam logic [15:0] PTR_STEP    = 16'h0002;
	localparam logic [4:0] CYC_CALL     = 5'h0E;
	localparam logic [4:0] CYC_RET      = 5'h0E;
	localparam logic [4:0] CYC_RET_EXT  = 5'h10;
	localparam logic [4:0] CYC_BYTE     = 5'h04;
	localparam logic [4:0] CYC_WORD     = 5'h08;
	localparam logic [4:0] CYC_HALT     = 5'h04;
	localparam logic [15:0] SP_RESET    = 16'h0000;
	localparam logic [15:0] PC_RESET    = 16'h0000;
	localparam logic [15:0] TP_RESET    = 16'h0000;
	localparam logic [7:0] FLG_RESET    = 8'h00;
	localparam int FLG_C = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_S = 5;
	localparam int FLG_V = 4;

	// register space access from the core
	typedef struct packed {
		logic       wr;
		logic [7:0] addr;
		logic [7:0] data;
	} tci_reg_req_t;

	// architectural pointers and flags
	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] tp;
		logic [7:0]  flags;
	} tci_arch_t;
endpackage

// file: tci_progrom.sv
// program memory word read port with registered output
`timescale 1ns/1ns
`default_nettype none
module tci_progrom
	import tci_pkg::*;
#(
	parameter int AW = 12
)(
	input  wire logic        sys_clk_in,
	input  wire logic        wr_in,
	input  wire logic [15:0] wr_addr_in,
	input  wire logic [7:0]  wr_data_in,
	input  wire logic [15:0] rd_addr_in,
	output logic [15:0]      rd_word_out
);
	logic [7:0] mem [2**AW];
	logic [AW-1:0] ra;
	logic [AW-1:0] rb;

	assign ra = rd_addr_in[AW-1:0];
	assign rb = AW'(ra + 1'b1);

	// loader write port; big-endian word read
	always_ff @(posedge sys_clk_in)
	begin
		if (wr_in)
			mem[wr_addr_in[AW-1:0]] <= wr_data_in;
		rd_word_out <= {mem[ra], mem[rb]};
	end
endmodule // tci_progrom
`default_nettype wire

// file: tci_regram.sv
// register space memory: 256 bytes, registered read data
`timescale 1ns/1ns
`default_nettype none
module tci_regram
	import tci_pkg::*;
#(
	parameter int DEPTH = 256
)(
	input  wire logic                  sys_clk_in,
	input  wire tci_pkg::tci_reg_req_t req_in,
	output logic [7:0]                 rd_data_out
);
	logic [7:0] mem [DEPTH];

	// read-first on a write (old byte returned), read registered
	always_ff @(posedge sys_clk_in)
	begin
		if (req_in.wr)
			mem[req_in.addr] <= req_in.data;
		rd_data_out <= mem[req_in.addr];
	end
endmodule // tci_regram
`default_nettype wire

// file: tci_rom_feeder.sv
// program memory writer on the loader port
`timescale 1ns/1ns
`default_nettype none
module tci_rom_feeder (
	input  wire logic   sys_clk_in,
	output logic        wr_out,
	output logic [15:0] addr_out,
	output logic [7:0]  data_out
);
	// idle at time zero
	initial
	begin
		wr_out = 1'b0;
		addr_out = 16'h0000;
		data_out = 8'h00;
	end
	// high byte first, then low byte, one per falling edge
	task automatic load(input logic [15:0] at, input logic [15:0] word);
		@(negedge sys_clk_in);
		wr_out = 1'b1;
		addr_out = at;
		data_out = word[15:8];
		@(negedge sys_clk_in);
		addr_out = at + 16'h0001;
		data_out = word[7:0];
		@(negedge sys_clk_in);
		wr_out = 1'b0;
		data_out = ~data_out; // released: stale byte not kept
	endtask
endmodule // tci_rom_feeder
`default_nettype wire
